// ==== rtl/nvc_host.sv ====
// Host controller that drives a nonvolatile SRAM over its asynchronous pins.
// Assumes pins are sampled in and out on i_ref_clk; wire levels resolved
// outside from the output enables.
module nvc_host #(
   parameter int SAVE_CYCLES = nvc_pkg::SAVE_CYC,
   parameter int RESTORE_CYCLES = nvc_pkg::RESTORE_CYC,
   parameter int CMD_CYCLES = nvc_pkg::CMD_CYC,
   parameter int SLEEP_CYCLES = nvc_pkg::SLEEP_CYC,
   parameter int WAKE_CYCLES = nvc_pkg::WAKE_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_req_valid,
   input wire nvc_pkg::nvc_req_type i_req,
   input wire logic [nvc_pkg::ADDR_W*nvc_pkg::CMD_LEN-1:0] i_seq_addr,
   input wire logic i_wake,
   input wire logic [nvc_pkg::DATA_W-1:0] i_dq,
   input wire logic i_hw_save_busy_n,
   output nvc_pkg::nvc_pins_type o_pins,
   output logic [nvc_pkg::DATA_W-1:0] o_dq,
   output logic o_dq_oe,
   output logic o_hw_save_busy_n,
   output logic o_hw_save_busy_oe,
   output logic o_req_ready,
   output logic o_rdata_valid,
   output logic [nvc_pkg::DATA_W-1:0] o_rdata,
   output logic o_asleep
);
   typedef enum {
      ST_POWERUP, ST_IDLE, ST_ACC, ST_GAP, ST_SAVE_PULSE, ST_WAIT,
      ST_SLEEP, ST_WAKE
   } nvc_state_type;

   nvc_state_type state;
   logic [nvc_pkg::CNT_W-1:0] cnt;
   logic [2:0] seq_idx;
   logic in_seq;
   logic is_read;
   logic [2:0] busy_sync;
   logic busy_level;

   // Three-stage sampling of the busy pin; a change counts once the last two
   // stages agree, so the first stage feeds only the second.
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         busy_sync <= 3'h7;
         busy_level <= 1'b1;
      end else begin
         busy_sync <= {busy_sync[1:0], i_hw_save_busy_n};
         if (busy_sync[2] == busy_sync[1]) begin
            busy_level <= busy_sync[1];
         end
      end
   end

   // Select decode helper used for every access strobe.
   function automatic nvc_pkg::nvc_pins_type sel_pins(
      input logic [nvc_pkg::ADDR_W-1:0] a, input logic rd,
      input logic [1:0] ln);
      nvc_pkg::nvc_pins_type p;
      p = nvc_pkg::PINS_IDLE;
      p.chip_select_low_active = 1'b0;
      p.chip_select_high_active = 1'b1;
      p.output_n = !rd;
      p.write_n = rd;
      p.upper_byte_lane_n = ln[1];
      p.lower_byte_lane_n = ln[0];
      p.addr = a;
      return p;
   endfunction

   // Main sequencer. Waits are conservative worst-case figures because the
   // device gives no completion signal beyond the busy pin.
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= ST_POWERUP;
         cnt <= '0;
         seq_idx <= 3'h0;
         in_seq <= 1'b0;
         is_read <= 1'b0;
         o_pins <= nvc_pkg::PINS_IDLE;
         o_dq <= '0;
         o_dq_oe <= 1'b0;
         o_hw_save_busy_n <= 1'b1;
         o_hw_save_busy_oe <= 1'b0;
         o_req_ready <= 1'b0;
         o_rdata_valid <= 1'b0;
         o_rdata <= '0;
         o_asleep <= 1'b0;
      end else begin
         o_rdata_valid <= 1'b0;
         case (state)
            ST_POWERUP: begin
               // Accesses are ignored during power-up restore.
               if (cnt == nvc_pkg::CNT_W'(RESTORE_CYCLES - 1)) begin
                  cnt <= '0;
                  state <= ST_IDLE;
                  o_req_ready <= 1'b1;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            ST_IDLE: begin
               if (i_req_valid && busy_level) begin
                  o_req_ready <= 1'b0;
                  cnt <= '0;
                  case (i_req.op)
                     nvc_pkg::OP_READ, nvc_pkg::OP_WRITE: begin
                        is_read <= (i_req.op == nvc_pkg::OP_READ);
                        o_pins <= sel_pins(i_req.addr,
                           i_req.op == nvc_pkg::OP_READ, i_req.lanes_n);
                        o_dq <= i_req.wdata;
                        o_dq_oe <= (i_req.op == nvc_pkg::OP_WRITE);
                        in_seq <= 1'b0;
                        state <= ST_ACC;
                     end
                     nvc_pkg::OP_SEQ: begin
                        // Commands go out only as reads.
                        is_read <= 1'b1;
                        in_seq <= 1'b1;
                        seq_idx <= 3'h0;
                        o_pins <= sel_pins(i_seq_addr[nvc_pkg::ADDR_W-1:0],
                           1'b1, 2'h0);
                        state <= ST_ACC;
                     end
                     nvc_pkg::OP_HWSAVE: begin
                        o_hw_save_busy_n <= 1'b0;
                        o_hw_save_busy_oe <= 1'b1;
                        state <= ST_SAVE_PULSE;
                     end
                     nvc_pkg::OP_SLEEP: begin
                        // No gap after a write is needed.
                        o_pins <= nvc_pkg::PINS_IDLE;
                        o_pins.sleep_request_n <= 1'b0;
                        state <= ST_SLEEP;
                     end
                     default: begin
                        o_req_ready <= 1'b1;
                     end
                  endcase
               end
            end
            ST_ACC: begin
               if (cnt == nvc_pkg::CNT_W'(nvc_pkg::ACCESS_CYC - 1)) begin
                  cnt <= '0;
                  if (is_read && !(in_seq && seq_idx == 3'h5)) begin
                     o_rdata <= i_dq;
                     o_rdata_valid <= !in_seq;
                  end
                  o_pins <= nvc_pkg::PINS_IDLE;
                  o_dq_oe <= 1'b0;
                  state <= ST_GAP;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            ST_GAP: begin
               // One deselected cycle splits reads into distinct cycles.
               if (in_seq && seq_idx != 3'(nvc_pkg::CMD_LEN - 1)) begin
                  seq_idx <= seq_idx + 1'b1;
                  o_pins <= sel_pins(i_seq_addr[(32'(seq_idx) + 1) *
                     nvc_pkg::ADDR_W +: nvc_pkg::ADDR_W], 1'b1, 2'h0);
                  state <= ST_ACC;
               end else if (in_seq) begin
                  in_seq <= 1'b0;
                  state <= ST_WAIT;
               end else begin
                  o_req_ready <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            ST_SAVE_PULSE: begin
               if (cnt == nvc_pkg::CNT_W'(nvc_pkg::SAVE_PULSE_CYC - 1)) begin
                  o_hw_save_busy_oe <= 1'b0;
                  o_hw_save_busy_n <= 1'b1;
                  cnt <= '0;
                  state <= ST_WAIT;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            ST_WAIT: begin
               // Hold off for the worst-case save time plus the command time.
               if (cnt == nvc_pkg::CNT_W'(SAVE_CYCLES + CMD_CYCLES)) begin
                  cnt <= '0;
                  if (busy_level) begin
                     o_req_ready <= 1'b1;
                     state <= ST_IDLE;
                  end
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            ST_SLEEP: begin
               if (cnt != nvc_pkg::CNT_W'(SLEEP_CYCLES)) begin
                  cnt <= cnt + 1'b1;
               end else begin
                  o_asleep <= 1'b1;
               end
               if (i_wake && o_asleep) begin
                  o_pins.sleep_request_n <= 1'b1;
                  o_asleep <= 1'b0;
                  cnt <= '0;
                  state <= ST_WAKE;
               end
            end
            ST_WAKE: begin
               if (cnt == nvc_pkg::CNT_W'(WAKE_CYCLES)) begin
                  cnt <= '0;
                  o_req_ready <= 1'b1;
                  state <= ST_IDLE;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Busy pin stays high whenever an access is on the bus.
   property p_busy_high_access;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (state == ST_ACC) |-> o_hw_save_busy_n;
   endproperty
   a_busy_high_access: assert property (p_busy_high_access)
      else $error("Save pin low during access.");

   // The save request pulse lasts at least the minimum width.
   property p_save_pulse;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         $fell(o_hw_save_busy_n) |-> !o_hw_save_busy_n [*2];
   endproperty
   a_save_pulse: assert property (p_save_pulse)
      else $error("Save request pulse too short.");

   // Reads for commands never assert the write strobe.
   property p_seq_write_high;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         in_seq |-> o_pins.write_n;
   endproperty
   a_seq_write_high: assert property (p_seq_write_high)
      else $error("Write strobe low in command sequence.");

   // No data is driven during a command sequence.
   property p_seq_read_only;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         in_seq |-> !o_dq_oe;
   endproperty
   a_seq_read_only: assert property (p_seq_read_only)
      else $error("Data driven in command sequence.");

   // An access always selects the device with both chip selects.
   property p_select;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (state == ST_ACC) |-> (!o_pins.chip_select_low_active &&
            o_pins.chip_select_high_active);
   endproperty
   a_select: assert property (p_select)
      else $error("Device not selected during access.");

   // After wake the controller stays off the bus until the wait ends.
   property p_wake_hold;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (state == ST_WAKE) |-> (o_pins.chip_select_low_active &&
            !o_req_ready);
   endproperty
   a_wake_hold: assert property (p_wake_hold)
      else $error("Access possible during wake wait.");
endmodule

// ==== rtl/nvc_pkg.sv ====
// Constants and carrier types for the nonvolatile SRAM host controller.
// Assumes a 100 MHz reference clock and an asynchronous memory outside.
// Function
// - Host holds save pin high during accesses
// - Host save request pulse at least 15 ns
// - Host waits 30 ms after sleep release
// - Sleep may follow last write immediately
// - Commands issued only as read cycles
// - Six command reads in order, write high
// - Sixth command read data is ignored
package nvc_pkg;
   localparam int CLK_MHZ = 100;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   // Timing figures in their own units and derived cycle counts.
   localparam int T_ACCESS_NS = 30;
   localparam int ACCESS_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int T_SAVE_PULSE_NS = 15;
   localparam int SAVE_PULSE_CYC = (T_SAVE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int T_SAVE_MS = 8;
   localparam int SAVE_CYC = T_SAVE_MS * CLK_MHZ * 1000;
   localparam int T_RESTORE_MS = 30;
   localparam int RESTORE_CYC = T_RESTORE_MS * CLK_MHZ * 1000;
   localparam int T_CMD_US = 500;
   localparam int T_SWREST_US = 600;
   localparam int CMD_CYC = (T_CMD_US + T_SWREST_US) * CLK_MHZ;
   localparam int T_SLEEP_MS = 8;
   localparam int SLEEP_CYC = T_SLEEP_MS * CLK_MHZ * 1000;
   localparam int T_WAKE_MS = 30;
   localparam int WAKE_CYC = T_WAKE_MS * CLK_MHZ * 1000;
   localparam int CNT_W = 24;
   localparam int CMD_LEN = 6;
   // Command codes on the user port.
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_WRITE = 3'h1;
   localparam logic [2:0] OP_SEQ = 3'h2;
   localparam logic [2:0] OP_HWSAVE = 3'h3;
   localparam logic [2:0] OP_SLEEP = 3'h4;

   typedef struct packed {
      logic [2:0] op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [1:0] lanes_n;
   } nvc_req_type;

   // Pin bundle towards the memory; all strobes active low except high CS.
   typedef struct packed {
      logic chip_select_low_active;
      logic chip_select_high_active;
      logic write_n;
      logic output_n;
      logic upper_byte_lane_n;
      logic lower_byte_lane_n;
      logic sleep_request_n;
      logic [ADDR_W-1:0] addr;
   } nvc_pins_type;

   localparam nvc_pins_type PINS_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1,
      1'b1, 20'h00000};
endpackage

// ==== testbench/nvc_mem_model.sv ====
// Behavioural model of the nonvolatile SRAM for the host controller bench.
// Assumes it shares the bench clock and that the bench resolves the wires.
module nvc_mem_model (
   input wire logic i_ref_clk,
   input wire nvc_pkg::nvc_pins_type i_pins,
   input wire logic [15:0] i_dq,
   input wire logic i_hw_save_busy_n,
   output logic [15:0] o_dq,
   output logic o_dq_oe,
   output logic o_hw_save_busy_n,
   output logic o_hw_save_busy_oe,
   output logic [7:0] o_n_save,
   output logic [7:0] o_n_read
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [16];
   logic latch = 1'b0;
   logic rd_prev = 1'b0;
   logic [7:0] busy_cnt = 8'h00;
   logic [7:0] n_save = 8'h00;
   logic [7:0] n_read = 8'h00;
   logic sel;
   logic rd;
   logic lanes_off;
   logic wr;
   logic save_go;
   // Only the low-active low, high-active high pair selects the part.
   assign sel = !i_pins.chip_select_low_active &&
      i_pins.chip_select_high_active;
   assign lanes_off = i_pins.upper_byte_lane_n && i_pins.lower_byte_lane_n;
   assign rd = sel && i_pins.write_n && !i_pins.output_n;
   // Data floats unless a read with a byte lane enabled runs outside a save; sleep deselects too.
   assign o_dq_oe = rd && !lanes_off && busy_cnt == 8'h00 &&
      i_pins.sleep_request_n;
   assign o_dq = mem[i_pins.addr[3:0]];
   // Busy is pulled low while saving, then driven high briefly. 
   assign o_hw_save_busy_n = busy_cnt <= 8'h02;
   assign o_hw_save_busy_oe = busy_cnt != 8'h00;
   assign o_n_save = n_save;
   assign o_n_read = n_read;
   // Write strobe decode and the start of a save with the latch set.
   assign wr = sel && !i_pins.write_n && !lanes_off;
   assign save_go = busy_cnt == 8'h00 && !i_hw_save_busy_n && latch;
   // Saves happen only with the write latch set; writes are locked out after the first 20 ns of a save.
   always @(posedge i_ref_clk) begin
      rd_prev <= rd;
      if (rd && !rd_prev) begin
         n_read <= n_read + 8'h01;
      end
      if (busy_cnt != 8'h00) begin
         busy_cnt <= busy_cnt - 8'h01;
      end else if (save_go) begin
         busy_cnt <= 8'h0c;
         latch <= 1'b0;
         n_save <= n_save + 8'h01;
      end else if (wr) begin
         latch <= 1'b1;
      end
      // A write in flight still lands for about 20 ns after a save starts,
      // so the host may finish it; later writes are dropped.
      if (wr && (busy_cnt == 8'h00 || busy_cnt >= 8'h0b)) begin
         if (!i_pins.lower_byte_lane_n) begin
            mem[i_pins.addr[3:0]][7:0] <= i_dq[7:0];
         end
         if (!i_pins.upper_byte_lane_n) begin
            mem[i_pins.addr[3:0]][15:8] <= i_dq[15:8];
         end
      end
   end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the nonvolatile SRAM host controller.
// Assumes the memory model file is compiled before this one.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, wake = 1'b0;
   nvc_pkg::nvc_req_type req = '0;
   logic [119:0] seq_addr = {20'h00005, 20'h00004, 20'h00003, 20'h00002,
      20'h00001, 20'h00000};
   nvc_pkg::nvc_pins_type pins;
   logic [15:0] d_dq, m_dq, rdata, r_val, dq_last = 16'h0000;
   logic d_oe, d_b, d_boe, m_oe, m_b, m_boe, ready, rvalid, asleep;
   logic [7:0] n_save, n_read, n0;
   logic [15:0] dq_w;
   logic busy_w;
   int n_fail = 0, checks_done = 0;
   // A released data bus shows a changing pattern, never a stale word.
   assign dq_w = d_oe ? d_dq : (m_oe ? m_dq : ~dq_last);
   assign busy_w = !((d_boe && !d_b) || (m_boe && !m_b));
   always @(posedge clk) dq_last <= dq_w;
   always #5 clk = ~clk;
   nvc_host #(.SAVE_CYCLES(20), .RESTORE_CYCLES(20), .CMD_CYCLES(20),
      .SLEEP_CYCLES(20), .WAKE_CYCLES(20)) u_dut (.i_ref_clk(clk),
      .i_reset_n(rst_n), .i_req_valid(valid), .i_req(req),
      .i_seq_addr(seq_addr), .i_wake(wake), .i_dq(dq_w),
      .i_hw_save_busy_n(busy_w), .o_pins(pins), .o_dq(d_dq), .o_dq_oe(d_oe),
      .o_hw_save_busy_n(d_b), .o_hw_save_busy_oe(d_boe), .o_req_ready(ready),
      .o_rdata_valid(rvalid), .o_rdata(rdata), .o_asleep(asleep));
   nvc_mem_model u_mem (.i_ref_clk(clk), .i_pins(pins), .i_dq(dq_w),
      .i_hw_save_busy_n(busy_w), .o_dq(m_dq), .o_dq_oe(m_oe),
      .o_hw_save_busy_n(m_b), .o_hw_save_busy_oe(m_boe), .o_n_save(n_save),
      .o_n_read(n_read));
   task automatic finish_test();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic send(logic [2:0] op, logic [19:0] a, logic [15:0] d,
      logic [1:0] ln);
      @(posedge clk);
      valid <= 1'b1;
      req <= '{op, a, d, ln};
      @(posedge clk);
      valid <= 1'b0;
   endtask
   // Waits for ready under a bound and keeps any read word seen meanwhile.
   task automatic wait_done(int bound);
      int i;
      r_val = 16'hxxxx;
      for (i = 0; i < bound; i++) begin
         @(posedge clk);
         #1;
         if (rvalid === 1'b1) r_val = rdata;
         if (i > 0 && ready === 1'b1) break;
      end
      if (ready !== 1'b1) begin
         check("ready wait", {15'h0000, ready}, 16'h0001);
         finish_test();
      end
   endtask
   task automatic t_rw();
      send(nvc_pkg::OP_WRITE, 20'h00003, 16'ha5c3, 2'b00);
      wait_done(50);
      send(nvc_pkg::OP_READ, 20'h00003, 16'h0000, 2'b00);
      wait_done(50);
      check("read word", r_val, 16'ha5c3);
      // Both lanes off must leave the stored word alone.
      send(nvc_pkg::OP_WRITE, 20'h00003, 16'h1234, 2'b11);
      wait_done(50);
      send(nvc_pkg::OP_READ, 20'h00003, 16'h0000, 2'b00);
      wait_done(50);
      check("lanes off", r_val, 16'ha5c3);
      // Only the upper lane is enabled, so the low byte must stay.
      send(nvc_pkg::OP_WRITE, 20'h00003, 16'h0f0f, 2'b01);
      wait_done(50);
      send(nvc_pkg::OP_READ, 20'h00003, 16'h0000, 2'b00);
      wait_done(50);
      check("upper lane", r_val, 16'h0fc3);
      $display("test rw done");
   endtask
   task automatic t_save();
      n0 = n_save;
      send(nvc_pkg::OP_HWSAVE, 20'h00000, 16'h0000, 2'b00);
      wait_done(300);
      check("save taken", {8'h00, n_save}, {8'h00, n0 + 8'h01});
      check("busy free", {15'h0000, busy_w}, 16'h0001);
      send(nvc_pkg::OP_HWSAVE, 20'h00000, 16'h0000, 2'b00);
      wait_done(300);
      check("save skipped", {8'h00, n_save}, {8'h00, n0 + 8'h01});
      send(nvc_pkg::OP_READ, 20'h00003, 16'h0000, 2'b00);
      wait_done(50);
      check("after save", r_val, 16'h0fc3);
      $display("test save done");
   endtask
   task automatic t_seq();
      n0 = n_read;
      send(nvc_pkg::OP_SEQ, 20'h00000, 16'h0000, 2'b00);
      // The command hold-off must still run well after the reads.
      repeat (30) @(posedge clk);
      #1;
      check("seq hold", {15'h0000, ready}, 16'h0000);
      wait_done(300);
      check("seq reads", {8'h00, n_read}, {8'h00, n0 + 8'h06});
      $display("test seq done");
   endtask
   task automatic t_refuse();
      n0 = n_read;
      send(3'h7, 20'h00000, 16'h0000, 2'b00);
      repeat (3) @(posedge clk);
      #1;
      check("bad op", {15'h0000, ready}, 16'h0001);
      check("bad op cs", {15'h0000, pins.chip_select_high_active},
         16'h0000);
      check("bad op reads", {8'h00, n_read}, {8'h00, n0});
      $display("test refuse done");
   endtask
   task automatic t_sleep();
      int i;
      send(nvc_pkg::OP_SLEEP, 20'h00000, 16'h0000, 2'b00);
      for (i = 0; i < 100 && asleep !== 1'b1; i++) @(posedge clk);
      #1;
      check("asleep", {15'h0000, asleep}, 16'h0001);
      check("sleep pin", {15'h0000, pins.sleep_request_n}, 16'h0000);
      check("dq float", {15'h0000, m_oe}, 16'h0000);
      @(posedge clk);
      wake <= 1'b1;
      // The host must keep off the bus through the wake wait.
      repeat (5) @(posedge clk);
      #1;
      check("wake hold", {15'h0000, ready}, 16'h0000);
      wait_done(200);
      wake <= 1'b0;
      check("woken pin", {15'h0000, pins.sleep_request_n}, 16'h0001);
      $display("test sleep done");
   endtask
   // Reset is held seventeen cycles, then the power-up restore wait runs.
   initial begin
      repeat (16) @(posedge clk);
      #1;
      check("rst ready", {15'h0000, ready}, 16'h0000);
      check("rst cs", {15'h0000, pins.chip_select_low_active}, 16'h0001);
      @(posedge clk);
      rst_n <= 1'b1;
      // Ready must not come before the power-up restore wait is over.
      repeat (10) @(posedge clk);
      #1;
      check("restore hold", {15'h0000, ready}, 16'h0000);
      wait_done(100);
      t_rw();
      t_save();
      t_seq();
      t_refuse();
      t_sleep();
      finish_test();
   end
endmodule
